// [hdl/mir_exec.sv]
// Execution sequencer for the move, idle and interrupt-return instructions
//
// Summary of operation
// - Move accumulator into addressed file register, one cycle
// - Interrupt return pops stack into program counter
// - Interrupt return sets global interrupt enable bit
// - Interrupt return occupies two instruction cycles
`timescale 1ns/10ps
module mir_exec #(
    parameter int PC_W = 13
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_instr_valid,
    input wire logic [13:0] i_instr,
    input wire logic [7:0] i_w,
    input wire logic [PC_W-1:0] i_stack_top,
    output logic o_ready,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    output logic o_stack_pop,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_pc_inc,
    output logic o_int_en_set,
    output logic o_unhandled
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Counter narrower than 9 bits cannot address the smallest program store
    if (PC_W < 9 || PC_W > 16) begin : g_pc_w_check
        $error("mir_exec: PC_W must lie between 9 and 16");
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic dec_move;
    logic dec_idle;
    logic dec_ret;
    logic dec_other;
    logic [6:0] dec_addr;

    mir_decode u_decode (
        .i_instr(i_instr),
        .o_is_move(dec_move),
        .o_is_idle(dec_idle),
        .o_is_ret(dec_ret),
        .o_is_other(dec_other),
        .o_file_addr(dec_addr)
    );

    // ------------------------------------------------------------------
    // Acceptance and next values
    // ------------------------------------------------------------------
    mir_pkg::mir_state_t state_reg;
    mir_pkg::mir_state_t state_next;
    logic ready_reg;
    logic ready_next;
    logic file_we_reg;
    logic [6:0] file_addr_reg;
    logic [7:0] file_wdata_reg;
    logic stack_pop_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_value_reg;
    logic pc_inc_reg;
    logic int_en_set_reg;
    logic unhandled_reg;

    // A word is taken only while no second cycle is pending
    wire logic accept;
    wire logic take_move;
    wire logic take_idle;
    wire logic take_ret;
    wire logic take_other;

    assign accept = i_instr_valid && ready_reg;
    assign take_move = accept && dec_move;
    assign take_idle = accept && dec_idle;
    assign take_ret = accept && dec_ret;
    assign take_other = accept && dec_other;

    // Sequencer: only the return needs a second cycle
    always_comb begin
        state_next = state_reg;
        ready_next = ready_reg;
        unique case (state_reg)
            mir_pkg::MIR_ST_FIRST: begin
                if (take_ret) begin
                    state_next = mir_pkg::MIR_ST_SECOND;
                    ready_next = 1'b0;
                end
            end
            mir_pkg::MIR_ST_SECOND: begin
                state_next = mir_pkg::MIR_ST_FIRST;
                ready_next = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Sequencer state
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= mir_pkg::MIR_ST_FIRST;
            ready_reg <= mir_pkg::RESET_READY;
        end else begin
            state_reg <= state_next;
            ready_reg <= ready_next;
        end
    end

    // One-cycle command pulses; no status flag port exists, so none can change
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            file_we_reg <= mir_pkg::RESET_PULSE;
            stack_pop_reg <= mir_pkg::RESET_PULSE;
            pc_load_reg <= mir_pkg::RESET_PULSE;
            pc_inc_reg <= mir_pkg::RESET_PULSE;
            int_en_set_reg <= mir_pkg::RESET_PULSE;
            unhandled_reg <= mir_pkg::RESET_PULSE;
        end else begin
            file_we_reg <= take_move;
            stack_pop_reg <= take_ret;
            pc_load_reg <= take_ret;
            pc_inc_reg <= take_move || take_idle;
            int_en_set_reg <= take_ret;
            unhandled_reg <= take_other;
        end
    end

    // Data fields load only with their command, so they hold between uses
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            file_addr_reg <= '0;
            file_wdata_reg <= '0;
            pc_value_reg <= '0;
        end else begin
            if (take_move) begin
                file_addr_reg <= dec_addr;
                file_wdata_reg <= i_w;
            end
            if (take_ret) begin
                pc_value_reg <= i_stack_top;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_ready = ready_reg;
    assign o_file_we = file_we_reg;
    assign o_file_addr = file_addr_reg;
    assign o_file_wdata = file_wdata_reg;
    assign o_stack_pop = stack_pop_reg;
    assign o_pc_load = pc_load_reg;
    assign o_pc_value = pc_value_reg;
    assign o_pc_inc = pc_inc_reg;
    assign o_int_en_set = int_en_set_reg;
    assign o_unhandled = unhandled_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Return: stall one cycle, then ready again
    sequence s_ret_taken;
        accept && dec_ret;
    endsequence

    sequence s_ret_stall_release;
        !o_ready ##1 o_ready;
    endsequence

    a_move_file_write:
    assert property (take_move |=> o_file_we && o_file_addr == $past(i_instr[6:0])
                     && o_file_wdata == $past(i_w))
        else $error("move did not write accumulator to addressed file");

    a_move_single_cycle:
    assert property (take_move |=> o_ready && !o_stack_pop && !o_int_en_set)
        else $error("move did not finish in one cycle");

    a_ret_pc_pop:
    assert property (s_ret_taken |=> o_stack_pop && o_pc_load
                     && o_pc_value == $past(i_stack_top))
        else $error("return did not load counter from stack top");

    a_ret_int_enable:
    assert property (s_ret_taken |=> o_int_en_set && !o_file_we)
        else $error("return did not set interrupt enable");

    a_ret_two_cycles:
    assert property (s_ret_taken |=> s_ret_stall_release)
        else $error("return did not take two cycles");

    a_idle_no_effect:
    assert property (take_idle |=> o_pc_inc && o_ready && !o_file_we && !o_stack_pop
                     && !o_pc_load && !o_int_en_set)
        else $error("idle changed state or stalled");

    a_we_has_cause:
    assert property (o_file_we |-> $past(take_move))
        else $error("file write without move instruction");

    a_int_enable_cause:
    assert property (o_int_en_set |-> $past(take_ret) && !o_pc_inc)
        else $error("interrupt enable set without return");

    // The stall cycle must not slip a held word through early
    a_stall_no_take:
    assert property (!o_ready |=> !o_file_we && !o_pc_inc && !o_stack_pop && !o_unhandled)
        else $error("word taken during return stall");

endmodule : mir_exec

// [hdl/mir_pkg.sv]
// Shared constants for the move and interrupt-return decode block
package mir_pkg;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int ADDR_LSB = 0;

    // ------------------------------------------------------------------
    // Opcode patterns: a word matches when (word & mask) == value
    // ------------------------------------------------------------------
    localparam logic [13:0] MOVE_MASK = 14'h3F80;
    localparam logic [13:0] MOVE_VALUE = 14'h0080;
    localparam logic [13:0] IDLE_MASK = 14'h3F9F;
    localparam logic [13:0] IDLE_VALUE = 14'h0000;
    localparam logic [13:0] RET_MASK = 14'h3FFF;
    localparam logic [13:0] RET_VALUE = 14'h0009;

    // ------------------------------------------------------------------
    // Interrupt control and timing
    // ------------------------------------------------------------------
    localparam int INT_ENABLE_POS = 7;
    localparam int MOVE_CYCLES = 1;
    localparam int IDLE_CYCLES = 1;
    localparam int RET_CYCLES = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RESET_READY = 1'b1;
    localparam logic RESET_PULSE = 1'b0;

    // Execution sequencer states
    typedef enum logic {
        MIR_ST_FIRST,
        MIR_ST_SECOND
    } mir_state_t;

endpackage : mir_pkg

// [hdl/mir_decode.sv]
// Combinational opcode decoder for the move, idle and interrupt-return group
`timescale 1ns/10ps
module mir_decode (
    input wire logic [13:0] i_instr,
    output logic o_is_move,
    output logic o_is_idle,
    output logic o_is_ret,
    output logic o_is_other,
    output logic [6:0] o_file_addr
);

    // ------------------------------------------------------------------
    // Pattern match
    // ------------------------------------------------------------------
    // Masks drop the address field and the two free bits of the idle word
    wire logic move_hit;
    wire logic idle_hit;
    wire logic ret_hit;

    assign move_hit = (i_instr & mir_pkg::MOVE_MASK) == mir_pkg::MOVE_VALUE;
    assign idle_hit = (i_instr & mir_pkg::IDLE_MASK) == mir_pkg::IDLE_VALUE;
    assign ret_hit = (i_instr & mir_pkg::RET_MASK) == mir_pkg::RET_VALUE;

    // Outputs; patterns are disjoint so no priority is needed
    assign o_is_move = move_hit;
    assign o_is_idle = idle_hit;
    assign o_is_ret = ret_hit;
    assign o_is_other = !(move_hit || idle_hit || ret_hit);
    assign o_file_addr = i_instr[mir_pkg::ADDR_LSB +: mir_pkg::ADDR_W];

endmodule : mir_decode

// [sim/move_and_interrupt_return_decode_test.sv]
// Self-checking bench for the move and interrupt-return execution sequencer
`timescale 1ns/10ps
module move_and_interrupt_return_decode_test;
    // Row: word, accumulator, stack top, expected {we,inc,pop,load,ien,unh,ready}
    typedef struct packed {
        logic [13:0] ins;
        logic [7:0] w;
        logic [12:0] top;
        logic [6:0] exp;
    } mir_row_t;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_instr_valid = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic [7:0] i_w = 8'h00;
    logic [12:0] i_stack_top = 13'h0000;
    logic o_ready, o_file_we, o_stack_pop, o_pc_load, o_pc_inc, o_int_en_set, o_unhandled;
    logic [6:0] o_file_addr;
    logic [7:0] o_file_wdata;
    logic [12:0] o_pc_value;
    wire logic [6:0] seen = {o_file_we, o_pc_inc, o_stack_pop, o_pc_load, o_int_en_set,
                             o_unhandled, o_ready};
    int miscompares = 0;
    int cmp_count = 0;
    logic [6:0] exp_addr = 7'h00;
    logic [7:0] exp_wd = 8'h00;
    logic [12:0] exp_pc = 13'h0000;
    // Ordinary cases; unknown words include neighbours of the group's opcodes
    mir_row_t rows [0:13] = '{
        '{14'h0080, 8'hA5, 13'h0000, 7'h61}, '{14'h00FF, 8'h3C, 13'h0000, 7'h61},
        '{14'h0000, 8'h77, 13'h0000, 7'h21}, '{14'h0020, 8'h77, 13'h0000, 7'h21},
        '{14'h0040, 8'h77, 13'h0000, 7'h21}, '{14'h0060, 8'h77, 13'h0000, 7'h21},
        '{14'h0009, 8'h77, 13'h1FFF, 7'h1C}, '{14'h0009, 8'h77, 13'h0ABC, 7'h1C},
        '{14'h0008, 8'h77, 13'h0123, 7'h03}, '{14'h0062, 8'h77, 13'h0000, 7'h03},
        '{14'h0100, 8'h77, 13'h0000, 7'h03}, '{14'h0010, 8'h77, 13'h0000, 7'h03},
        '{14'h0089, 8'h5A, 13'h0000, 7'h61}, '{14'h2080, 8'h77, 13'h0000, 7'h03}};

    mir_exec #(.PC_W(13)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_w(i_w),
        .i_stack_top(i_stack_top), .o_ready(o_ready), .o_file_we(o_file_we),
        .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata), .o_stack_pop(o_stack_pop),
        .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_pc_inc(o_pc_inc),
        .o_int_en_set(o_int_en_set), .o_unhandled(o_unhandled));

    // ----------------------------------------------------------------
    // Checking and closing tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk

    // Held values are compared every time, so a stray update shows up
    task automatic outs(input logic [6:0] e);
        chk({9'h000, seen}, {9'h000, e});
        chk({9'h000, o_file_addr}, {9'h000, exp_addr});
        chk({8'h00, o_file_wdata}, {8'h00, exp_wd});
        chk({3'h0, o_pc_value}, {3'h0, exp_pc});
    endtask : outs

    task automatic complete_run;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // One word offered for one edge, answer checked one cycle later
    task automatic issue(input mir_row_t r);
        @(posedge i_clk);
        i_instr_valid <= 1'b1;
        i_instr <= r.ins;
        i_w <= r.w;
        i_stack_top <= r.top;
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
        if (r.exp == 7'h61) begin
            exp_addr = r.ins[6:0];
            exp_wd = r.w;
        end
        if (r.exp == 7'h1C) begin
            exp_pc = r.top;
        end
        #1;
        outs(r.exp);
    endtask : issue

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    // Bounded run: a hang counts as a failure
    initial begin
        repeat (3000) @(posedge i_clk);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (11) @(posedge i_clk);
        #1;
        outs(7'h01);
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        foreach (rows[i]) begin
            issue(rows[i]);
        end
        // Back-to-back moves every cycle
        @(posedge i_clk);
        i_instr_valid <= 1'b1;
        i_instr <= 14'h0085;
        i_w <= 8'h11;
        @(posedge i_clk);
        i_instr <= 14'h00FE;
        i_w <= 8'h22;
        #1;
        exp_addr = 7'h05;
        exp_wd = 8'h11;
        outs(7'h61);
        // Return with a move held behind it: one refused edge, then taken
        @(posedge i_clk);
        i_instr <= 14'h0009;
        i_stack_top <= 13'h1555;
        #1;
        exp_addr = 7'h7E;
        exp_wd = 8'h22;
        outs(7'h61);
        @(posedge i_clk);
        i_instr <= 14'h0090;
        i_w <= 8'h33;
        #1;
        exp_pc = 13'h1555;
        outs(7'h1C);
        @(posedge i_clk);
        #1;
        outs(7'h01);
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
        #1;
        exp_addr = 7'h10;
        exp_wd = 8'h33;
        outs(7'h61);
        // Reset in mid-run clears held values without a clock edge
        #3;
        i_arst_n <= 1'b0;
        #1;
        exp_addr = 7'h00;
        exp_wd = 8'h00;
        exp_pc = 13'h0000;
        outs(7'h01);
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        issue(rows[7]);
        complete_run();
    end
endmodule : move_and_interrupt_return_decode_test
